// ==== hw/fblc_pkg.sv ====
// Package for the flash block lock control: command codes, status bits,
// block address layout and shared types.
// Assumes a 16-bit command/data word and a word address bus.
package fblc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BLK_ADDR_LSB = 12;
  localparam int NUM_BLOCKS = 16;
  localparam int BLK_W = 4;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_UNLOCK = 8'hD0;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [ADDR_W-1:0] LOCK_STATUS_OFS = 16'h0002;
  localparam int SR_BLOCK_LOCK = 1;
  localparam int SR_VPP_ERR = 3;
  localparam int SR_SEQ_ERR_LO = 4;
  localparam int SR_SEQ_ERR_HI = 5;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_READY = 7;
  localparam int LOCKED_BIT = 0;
  localparam int LOCKDOWN_BIT = 1;
  localparam logic [DATA_W-1:0] SR_RESET = 16'h0080;
  // Host register map on AHB-Lite
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [31:0] REG_UNMAPPED = 32'h0000_0000;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_WRITE_BIT = 31;
  typedef enum logic [1:0] {
    FBLC_RD_ARRAY = 2'b00,
    FBLC_RD_STATUS = 2'b01,
    FBLC_RD_ID = 2'b11
  } fblc_rmode_t;
  typedef enum logic [1:0] {
    FBLC_H_IDLE = 2'b00,
    FBLC_H_DRIVE = 2'b01,
    FBLC_H_DONE = 2'b11
  } fblc_hstate_t;
endpackage

// ==== hw/fblc_if.sv ====
// Interface joining the flash lock device and its host controller.
// Assumes a single synchronous clock shared by both ends.
`timescale 1ns/1ps
interface fblc_if;
  import fblc_pkg::*;
  logic we_n;
  logic oe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic wp_n;
  logic rst_n;
  logic vpp_ok;
  modport device (input we_n, oe_n, addr, wdata, wp_n, rst_n, vpp_ok,
                  output rdata);
  modport host (output we_n, oe_n, addr, wdata, wp_n, rst_n, vpp_ok,
                input rdata);
endinterface

// ==== hw/fblc_lock_cell.sv ====
// One block's lock and lock-down bits.
// Assumes the command decoder gives at most one strobe per cycle.
`timescale 1ns/1ps
module fblc_lock_cell (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic wp_n_in,
  input wire logic lock_in,
  input wire logic unlock_in,
  input wire logic lockdown_in,
  output logic locked_out,
  output logic lockdown_out
);
  import fblc_pkg::*;
  logic locked;
  logic lockdown;
  logic next_locked;
  logic next_lockdown;
  always_comb begin
    next_locked = locked;
    next_lockdown = lockdown;
    if (lockdown_in) begin
      next_lockdown = 1'b1;
      next_locked = 1'b1;
    end else if (lock_in) begin
      next_locked = 1'b1;
    end else if (unlock_in && !(lockdown && !wp_n_in)) begin
      next_locked = 1'b0;
    end
    // State [011]: write-protect low holds a locked-down block locked
    if (lockdown && !wp_n_in) begin
      next_locked = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      locked <= 1'b1;
      lockdown <= 1'b0;
    end else begin
      locked <= next_locked;
      lockdown <= next_lockdown;
    end
  end
  // Tuple seen as {wp_n, lockdown, locked}
  assign locked_out = locked;
  assign lockdown_out = lockdown;
endmodule

// ==== hw/fblc_device.sv ====
// Flash-side lock control: command decode, per-block lock cells,
// status word, identifier readout and program/erase gating.
// Assumes the host keeps we_n low for one clock per command write.
// Operation
// - Reset leaves every block locked, not locked-down
// - Program/erase on locked block sets status bit 1
// - Block state is tuple write-protect, lock-down, lock
// - Lock change: 60h then 01h, D0h or 2Fh
// - Unlock only when block not held locked-down
// - Lock-down confirm sets lock-down and lock bits
// - Only reset clears the lock-down bit
// - Write-protect affects only locked-down blocks
// - Write-protect low forces locked-down blocks locked
// - Write-protect high makes locked-down blocks unlockable
// - Reset relocks every unlocked block
// - Identifier mode at base plus 02h shows bits
// - Lock bits work with program supply low
// - Supply low refuses program/erase; reset pin refuses all
// - Lock commands apply during erase suspend
// - No lock change while program suspended
// - Bad second command after 60h sets bits 5:4
// - Lock error bits persist after erase resumes
// - Host suspends erase, checks bit 6, then locks
// - Host returns to array read with FFh
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module fblc_device #(
  parameter int NBLK = fblc_pkg::NUM_BLOCKS
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  fblc_if.device link,
  output logic [NBLK-1:0] locked_out,
  output logic [NBLK-1:0] lockdown_out,
  output logic prog_ok_out,
  output logic erase_ok_out,
  output logic [fblc_pkg::BLK_W-1:0] op_block_out,
  output logic erase_suspended_out
);
  import fblc_pkg::*;

  function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    blk_of = a[BLK_ADDR_LSB +: BLK_W];
  endfunction

  logic rst_ok;
  logic wr;
  logic [7:0] cmd;
  logic [BLK_W-1:0] blk;
  logic [NBLK-1:0] cell_locked;
  logic [NBLK-1:0] cell_lockdown;
  logic [NBLK-1:0] lock_stb;
  logic [NBLK-1:0] unlock_stb;
  logic [NBLK-1:0] lockdown_stb;

  logic lock_setup;
  logic prog_setup;
  logic erase_setup;
  logic erase_susp;
  logic prog_susp;
  logic erase_run;
  logic prog_run;
  fblc_rmode_t rmode;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] rdata;
  logic prog_ok;
  logic erase_ok;
  logic [BLK_W-1:0] op_block;

  logic next_lock_setup;
  logic next_prog_setup;
  logic next_erase_setup;
  logic next_erase_susp;
  logic next_prog_susp;
  logic next_erase_run;
  logic next_prog_run;
  fblc_rmode_t next_rmode;
  logic [DATA_W-1:0] next_status;
  logic [DATA_W-1:0] next_rdata;
  logic next_prog_ok;
  logic next_erase_ok;
  logic [BLK_W-1:0] next_op_block;

  // Reset pin low locks everything and refuses every access
  assign rst_ok = nrst_in && link.rst_n;
  assign wr = !link.we_n;
  assign cmd = link.wdata[7:0];
  assign blk = blk_of(link.addr);

  genvar g;
  generate
    for (g = 0; g < NBLK; g++) begin : g_cell
      fblc_lock_cell u_cell (
        .sys_clk_in(sys_clk_in),
        .nrst_in(rst_ok),
        .wp_n_in(link.wp_n),
        .lock_in(lock_stb[g]),
        .unlock_in(unlock_stb[g]),
        .lockdown_in(lockdown_stb[g]),
        .locked_out(cell_locked[g]),
        .lockdown_out(cell_lockdown[g])
      );
    end
  endgenerate

  always_comb begin
    lock_stb = '0;
    unlock_stb = '0;
    lockdown_stb = '0;
    // A setup stays pending until the next command write consumes it
    next_lock_setup = lock_setup && !wr;
    next_prog_setup = prog_setup && !wr;
    next_erase_setup = erase_setup && !wr;
    next_erase_susp = erase_susp;
    next_prog_susp = prog_susp;
    // Erase and program complete one cycle after their start
    next_erase_run = 1'b0;
    next_prog_run = 1'b0;
    next_rmode = rmode;
    next_status = status;
    next_rdata = rdata;
    next_prog_ok = 1'b0;
    next_erase_ok = 1'b0;
    next_op_block = op_block;
    if (erase_run) begin
      next_erase_susp = 1'b0;
    end
    if (wr) begin
      if (lock_setup) begin
        // Second cycle of a lock sequence; supply level is not checked
        next_rmode = FBLC_RD_STATUS;
        if (prog_susp) begin
          next_status[SR_SEQ_ERR_HI] = 1'b1;
          next_status[SR_SEQ_ERR_LO] = 1'b1;
        end else if (cmd == CMD_LOCK) begin
          lock_stb[blk] = 1'b1;
        end else if (cmd == CMD_UNLOCK) begin
          unlock_stb[blk] = 1'b1;
        end else if (cmd == CMD_LOCKDOWN) begin
          lockdown_stb[blk] = 1'b1;
        end else begin
          // Error bits stay set across a later erase resume
          next_status[SR_SEQ_ERR_HI] = 1'b1;
          next_status[SR_SEQ_ERR_LO] = 1'b1;
        end
      end else if (prog_setup || erase_setup) begin
        next_rmode = FBLC_RD_STATUS;
        next_op_block = blk;
        if (!link.vpp_ok) begin
          next_status[SR_VPP_ERR] = 1'b1;
        end else if (cell_locked[blk]) begin
          next_status[SR_BLOCK_LOCK] = 1'b1;
        end else if (prog_setup) begin
          next_prog_ok = 1'b1;
          next_prog_run = 1'b1;
        end else if (cmd == CMD_RESUME) begin
          next_erase_ok = 1'b1;
          next_erase_run = 1'b1;
        end else begin
          next_status[SR_SEQ_ERR_HI] = 1'b1;
          next_status[SR_SEQ_ERR_LO] = 1'b1;
        end
      end else begin
        case (cmd)
          CMD_LOCK_SETUP: next_lock_setup = 1'b1;
          CMD_PROGRAM: next_prog_setup = !erase_run;
          CMD_ERASE_SETUP: next_erase_setup = !erase_susp;
          CMD_READ_ID: next_rmode = FBLC_RD_ID;
          CMD_READ_ARRAY: next_rmode = FBLC_RD_ARRAY;
          CMD_READ_STATUS: next_rmode = FBLC_RD_STATUS;
          CMD_CLEAR_STATUS: next_status = SR_RESET;
          CMD_SUSPEND: begin
            next_erase_susp = 1'b1;
            next_status[SR_ERASE_SUSP] = 1'b1;
          end
          // Resume: a suspended erase on op_block completes only when supply is good
          CMD_RESUME: begin
            next_erase_susp = 1'b0;
            next_prog_susp = 1'b0;
            next_status[SR_ERASE_SUSP] = 1'b0;
            next_erase_ok = erase_susp && link.vpp_ok;
          end
          default: next_rmode = rmode;
        endcase
      end
    end
    if (!link.oe_n) begin
      case (rmode)
        FBLC_RD_STATUS: next_rdata = status;
        FBLC_RD_ID: begin
          next_rdata = '0;
          if ((link.addr & ((ADDR_W)'(1) << BLK_ADDR_LSB) - 1'b1)
              == LOCK_STATUS_OFS) begin
            next_rdata[LOCKED_BIT] = cell_locked[blk];
            next_rdata[LOCKDOWN_BIT] = cell_lockdown[blk];
          end
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_ok) begin
      lock_setup <= 1'b0;
      prog_setup <= 1'b0;
      erase_setup <= 1'b0;
      erase_susp <= 1'b0;
      prog_susp <= 1'b0;
      erase_run <= 1'b0;
      prog_run <= 1'b0;
      rmode <= FBLC_RD_ARRAY;
      status <= SR_RESET;
      rdata <= '0;
      prog_ok <= 1'b0;
      erase_ok <= 1'b0;
      op_block <= '0;
    end else begin
      lock_setup <= next_lock_setup;
      prog_setup <= next_prog_setup;
      erase_setup <= next_erase_setup;
      erase_susp <= next_erase_susp;
      prog_susp <= next_prog_susp;
      erase_run <= next_erase_run;
      prog_run <= next_prog_run;
      rmode <= next_rmode;
      status <= next_status;
      rdata <= next_rdata;
      prog_ok <= next_prog_ok;
      erase_ok <= next_erase_ok;
      op_block <= next_op_block;
    end
  end

  assign link.rdata = rdata;
  assign locked_out = cell_locked;
  assign lockdown_out = cell_lockdown;
  assign prog_ok_out = prog_ok;
  assign erase_ok_out = erase_ok;
  assign op_block_out = op_block;
  assign erase_suspended_out = erase_susp;
endmodule

// ==== hw/fblc_host.sv ====
// Host controller: AHB-Lite slave taking command writes and read
// requests from software and replaying them on the flash link.
// Assumes one outstanding flash access at a time.
`timescale 1ns/1ps
module fblc_host (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  fblc_if.host link,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic wp_n_in,
  input wire logic vpp_ok_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);
  import fblc_pkg::*;
  fblc_hstate_t st;
  fblc_hstate_t next_st;
  logic dp_wr;
  logic next_dp_wr;
  logic [7:0] dp_addr;
  logic [7:0] next_dp_addr;
  logic [31:0] hrdata;
  logic [31:0] next_hrdata;
  logic hready;
  logic next_hready;
  logic we_n;
  logic next_we_n;
  logic oe_n;
  logic next_oe_n;
  logic [ADDR_W-1:0] faddr;
  logic [ADDR_W-1:0] next_faddr;
  logic [DATA_W-1:0] fwdata;
  logic [DATA_W-1:0] next_fwdata;
  logic [DATA_W-1:0] last;
  logic [DATA_W-1:0] next_last;
  logic cmd_wr;

  assign cmd_wr = dp_wr && dp_addr == REG_CMD;

  always_comb begin
    next_st = st;
    next_dp_wr = dp_wr;
    next_dp_addr = dp_addr;
    next_hrdata = hrdata;
    next_hready = hready;
    next_we_n = 1'b1;
    next_oe_n = 1'b1;
    next_faddr = faddr;
    next_fwdata = fwdata;
    next_last = last;
    case (st)
      FBLC_H_IDLE: begin
        if (hsel_in && htrans_in[1] && hready_in) begin
          next_dp_wr = hwrite_in;
          next_dp_addr = haddr_in[7:0];
          next_hready = 1'b0;
          next_st = FBLC_H_DRIVE;
        end
      end
      FBLC_H_DRIVE: begin
        next_st = FBLC_H_DONE;
        if (cmd_wr) begin
          // Bit 31 selects flash write, else flash read
          // Bit 31 doubles as the write flag, so address bit 15 is
          // forced low: only the lower half of the blocks is reachable
          next_faddr = {1'b0, hwdata_in[CMD_ADDR_LSB +: ADDR_W-1]};
          next_fwdata = hwdata_in[DATA_W-1:0];
          next_we_n = !hwdata_in[CMD_WRITE_BIT];
          next_oe_n = hwdata_in[CMD_WRITE_BIT];
        end
        case (dp_addr)
          REG_STATUS: next_hrdata = {16'h0000, last};
          REG_RDATA: next_hrdata = {16'h0000, link.rdata};
          default: next_hrdata = REG_UNMAPPED;
        endcase
      end
      FBLC_H_DONE: begin
        next_last = link.rdata;
        next_hready = 1'b1;
        next_dp_wr = 1'b0;
        next_st = FBLC_H_IDLE;
      end
      default: next_st = FBLC_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      st <= FBLC_H_IDLE;
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hready <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      faddr <= '0;
      fwdata <= '0;
      last <= '0;
    end else begin
      st <= next_st;
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      hready <= next_hready;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      faddr <= next_faddr;
      fwdata <= next_fwdata;
      last <= next_last;
    end
  end

  assign link.we_n = we_n;
  assign link.oe_n = oe_n;
  assign link.addr = faddr;
  assign link.wdata = fwdata;
  assign link.wp_n = wp_n_in;
  assign link.rst_n = nrst_in;
  assign link.vpp_ok = vpp_ok_in;
  assign hrdata_out = hrdata;
  assign hreadyout_out = hready;
  assign hresp_out = 1'b0;
endmodule

// ==== tb/fblc_sva.sv ====
// Checker on the link between the flash lock host and device.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module fblc_sva
  import fblc_pkg::*;
#(
  parameter int NBLK = 16
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic wp_n,
  input wire logic rst_n,
  input wire logic vpp_ok,
  input wire logic [NBLK-1:0] locked_out,
  input wire logic [NBLK-1:0] lockdown_out,
  input wire logic prog_ok_out,
  input wire logic erase_ok_out
);
  logic wr;
  logic armed;
  logic idm;
  logic [3:0] blk;
  assign wr = !we_n && rst_n;
  assign blk = addr[15:12];
  // Tracks a pending setup write and identifier read mode
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      armed <= 1'h0;
      idm <= 1'h0;
    end else if (wr) begin
      armed <= !armed && wdata[7:0] == CMD_LOCK_SETUP;
      idm <= !armed && wdata[7:0] == CMD_READ_ID;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_conf(logic [7:0] c);
    armed && wr && wdata[7:0] == c;
  endsequence
  AST_LOCK: assert property (
    s_conf(CMD_LOCK) |=> locked_out[$past(blk)])
    else $error("lock confirm left block unlocked");
  AST_LOCKDOWN: assert property (
    s_conf(CMD_LOCKDOWN) |=>
      locked_out[$past(blk)] && lockdown_out[$past(blk)])
    else $error("lock-down confirm did not set both bits");
  AST_UNLOCK: assert property (
    s_conf(CMD_UNLOCK) ##0 (wp_n || !lockdown_out[blk]) |=>
      !locked_out[$past(blk)])
    else $error("unlock confirm did not clear lock bit");
  AST_UNLOCK_HELD: assert property (
    s_conf(CMD_UNLOCK) ##0 (!wp_n && lockdown_out[blk]) |=>
      locked_out[$past(blk)])
    else $error("held block was unlocked");
  AST_TARGET_ONLY: assert property (
    armed && wr |=> ((locked_out ^ $past(locked_out)) &
      ~(NBLK'(1) << $past(blk))) == '0)
    else $error("lock change hit another block");
  AST_LD_STICKY: assert property (
    rst_n |-> ($past(lockdown_out) & ~lockdown_out) == '0)
    else $error("lock-down bit cleared without reset");
  AST_RESET: assert property (
    $rose(nrst_in) |-> locked_out == '1 && lockdown_out == '0)
    else $error("blocks not locked after reset");
  AST_WP_FORCE: assert property (
    !wp_n && !$past(wp_n) |-> (lockdown_out & ~locked_out) == '0)
    else $error("locked-down block unlocked under write-protect");
  AST_ID_READ: assert property (
    idm && !oe_n && rst_n && addr[11:0] == 12'h002 |=>
      rdata[1:0] == {$past(lockdown_out[blk]), $past(locked_out[blk])})
    else $error("lock status read back wrong");
  AST_VPP_GATE: assert property (
    prog_ok_out || erase_ok_out |-> vpp_ok)
    else $error("program or erase allowed with supply low");
endmodule

// ==== tb/fblc_tb.sv ====
// Testbench joining host and device over the link; drives AHB-Lite.
// Assumes blocks 0 to 7 only, since command bit 31 flags a write.
`timescale 1ns/1ps
module fblc_tb;
  import fblc_pkg::*;
  logic sys_clk, nrst, hsel, hwrite, wp, vpp, hready, hresp, rd_pend;
  logic prog_ok, erase_ok, esusp, w;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, bb;
  logic [15:0] locked, lockdown;
  logic [3:0] op_blk;
  logic [7:0] lk, ld;
  logic [15:0] eq[$];
  logic [15:0] mq[$];
  int err_count, tests_run, op;
  int seed = 32'h1D5E8E94;
  fblc_if u_fblc_if();
  fblc_host u_fblc_host(.sys_clk_in(sys_clk), .nrst_in(nrst),
    .link(u_fblc_if), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .wp_n_in(wp),
    .vpp_ok_in(vpp), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp));
  fblc_device #(.NBLK(16)) u_fblc_device(.sys_clk_in(sys_clk),
    .nrst_in(nrst), .link(u_fblc_if), .locked_out(locked),
    .lockdown_out(lockdown), .prog_ok_out(prog_ok),
    .erase_ok_out(erase_ok), .op_block_out(op_blk),
    .erase_suspended_out(esusp));
  fblc_sva #(.NBLK(16)) u_fblc_sva(.sys_clk_in(sys_clk), .nrst_in(nrst),
    .we_n(u_fblc_if.we_n), .oe_n(u_fblc_if.oe_n),
    .addr(u_fblc_if.addr), .wdata(u_fblc_if.wdata),
    .rdata(u_fblc_if.rdata), .wp_n(u_fblc_if.wp_n),
    .rst_n(u_fblc_if.rst_n), .vpp_ok(u_fblc_if.vpp_ok),
    .locked_out(locked), .lockdown_out(lockdown),
    .prog_ok_out(prog_ok), .erase_ok_out(erase_ok));
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  task close_out();
    $display("errors %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge sys_clk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= !wr;
    do @(posedge sys_clk); while (!hready);
    rd_pend <= 1'h0;
  endtask
  task fw(input logic [2:0] b, input logic [7:0] c);
    ahb(1'h1, REG_CMD, {1'h1, b, 12'h0, 8'h0, c});
  endtask
  task frd(input logic [2:0] b, input logic [15:0] e, m);
    ahb(1'h1, REG_CMD, {1'h0, b, 12'h002, 16'h0});
    // Live data first; the status copy is current only after that read
    eq.push_back(e);
    mq.push_back(m);
    ahb(1'h0, REG_RDATA, 32'h0);
    eq.push_back(e);
    mq.push_back(m);
    ahb(1'h0, REG_STATUS, 32'h0);
  endtask
  task fid(input logic [2:0] b, input logic [1:0] e);
    fw(b, CMD_READ_ID);
    frd(b, {14'h0, e}, 16'h0003);
  endtask
  task fst(input logic [15:0] e);
    fw(3'h0, CMD_READ_STATUS);
    frd(3'h0, e, e);
  endtask
  // Compares every read result against the oldest expectation
  always @(posedge sys_clk) begin
    if (rd_pend && hready)
      chk(hrdata[15:0] & mq.pop_front(), eq.pop_front());
  end
  initial begin
    repeat (50000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
  initial begin
    hsel = 1'h1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wp = 1'h1;
    vpp = 1'h1;
    nrst = 1'h0;
    rd_pend = 1'h0;
    lk = 8'hFF;
    ld = 8'h00;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'h1;
    for (int b = 0; b < 8; b++) fid(3'(b), 2'h1);
    ahb(1'h1, 8'h10, 32'hFFFF_FFFF);
    frd(3'h0, 16'h0001, 16'hFFFF);
    eq.push_back(16'h0);
    mq.push_back(16'hFFFF);
    ahb(1'h0, 8'h0C, 32'h0);
    fw(3'h0, CMD_CLEAR_STATUS);
    fw(3'h1, CMD_PROGRAM);
    fw(3'h1, 8'h5A);
    fst(16'h0002);
    fw(3'h0, CMD_CLEAR_STATUS);
    fw(3'h2, CMD_LOCK_SETUP);
    fw(3'h2, 8'h55);
    fst(16'h0030);
    fid(3'h2, 2'h1);
    vpp <= 1'h0;
    fw(3'h0, CMD_CLEAR_STATUS);
    fw(3'h3, CMD_LOCK_SETUP);
    fw(3'h3, CMD_UNLOCK);
    fid(3'h3, 2'h0);
    fw(3'h3, CMD_PROGRAM);
    fw(3'h3, 8'hA5);
    fst(16'h0008);
    vpp <= 1'h1;
    fw(3'h0, CMD_CLEAR_STATUS);
    fw(3'h3, CMD_PROGRAM);
    fw(3'h3, 8'h5A);
    fw(3'h0, CMD_READ_STATUS);
    frd(3'h0, 16'h0080, 16'h00FF);
    fw(3'h3, CMD_ERASE_SETUP);
    fw(3'h3, CMD_RESUME);
    fw(3'h3, CMD_SUSPEND);
    chk({12'h0, op_blk}, 16'h0003);
    chk({15'h0, esusp}, 16'h0001);
    fw(3'h3, CMD_LOCK_SETUP);
    fw(3'h3, CMD_LOCK);
    fid(3'h3, 2'h1);
    fw(3'h3, CMD_LOCK_SETUP);
    fw(3'h3, 8'h55);
    fw(3'h3, CMD_RESUME);
    chk({15'h0, esusp}, 16'h0000);
    fst(16'h0030);
    for (int i = 0; i < 40; i++) begin
      bb = 3'($random(seed));
      op = $unsigned($random(seed)) % 3;
      w = 1'($random(seed));
      wp <= w;
      vpp <= 1'($random(seed));
      if (!w) lk = lk | ld;
      fw(3'($random(seed)), CMD_LOCK_SETUP);
      case (op)
        0: begin
          fw(bb, CMD_LOCK);
          lk[bb] = 1'h1;
        end
        1: begin
          fw(bb, CMD_UNLOCK);
          if (w || !ld[bb]) lk[bb] = 1'h0;
        end
        default: begin
          fw(bb, CMD_LOCKDOWN);
          lk[bb] = 1'h1;
          ld[bb] = 1'h1;
        end
      endcase
      fid(bb, {ld[bb], lk[bb]});
    end
    nrst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'h1;
    for (int b = 0; b < 8; b++) fid(3'(b), 2'h1);
    fw(3'h0, CMD_READ_ARRAY);
    frd(3'h0, 16'h0000, 16'hFFFF);
    close_out();
  end
endmodule
